// *** logic/tap_regs.svh ***
// Constants of the boundary-scan test access port.
`ifndef TAP_REGS_SVH
`define TAP_REGS_SVH
`define IR_WIDTH 4
`define IR_EXTEST 4'h0
`define IR_SAMPLE 4'h1
`define IR_IDCODE 4'h2
`define IR_INTEST 4'h3
`define IR_CLAMP 4'h4
`define IR_PRIVATE 4'h8
`define IR_BYPASS 4'hF
`define IR_CAPTURE 4'h1
`define ID_WIDTH 32
`define ID_VERSION_MSB 31
`define ID_VERSION_LSB 28
`define ID_PART_MSB 27
`define ID_PART_LSB 12
`define ID_MFR_MSB 11
`define ID_MFR_LSB 1
`define ID_MARKER_BIT 0
`endif

// *** logic/tap_pkg.sv ***
// Types shared by the boundary-scan test access port.
package tap_pkg;
  typedef enum logic [15:0] {
    TLR = 16'h0001, RTI = 16'h0002, SDS = 16'h0004, CDR = 16'h0008,
    SDR = 16'h0010, E1D = 16'h0020, PDR = 16'h0040, E2D = 16'h0080,
    UDR = 16'h0100, SIS = 16'h0200, CIR = 16'h0400, SIR = 16'h0800,
    E1I = 16'h1000, PIR = 16'h2000, E2I = 16'h4000, UIR = 16'h8000
  } tap_state_t;

  typedef struct packed {
    logic tms;
    logic tdi;
  } scan_in_t;

  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } scan_out_t;

  typedef struct packed {
    logic test_mode;
    logic clamp;
    logic intest;
    logic private_test;
  } test_ctrl_t;
endpackage

// *** logic/tap_sync.sv ***
// Two-flop synchroniser for a level crossing into another clock domain.
`timescale 1ns/1ps
module tap_sync
#(
  parameter int WIDTH = 1
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else if (ce)
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // tap_sync

// *** logic/boundary_scan_tap.sv ***
// Boundary-scan test access port with identification and boundary chain.
//
// Functional notes
// [R1] Five test pins: mode select, test clock, test reset, data in, out.
// [R2] Decodes bypass, extest, intest, sample, clamp and idcode.
// [R3] Controller rests in Test-Logic-Reset during functional operation.
// [R4] Test-Logic-Reset loads idcode into the instruction register.
// [R5] Test reset low forces Test-Logic-Reset without the test clock.
// [R6] Idcode puts the identification register between data in and out.
// [R7] Capture-DR under idcode loads the code; Shift-DR shifts it out.
// [R8] Identification register is 32 bits, bit 0 nearest data out.
// [R9] Code holds manufacturer, part number and version fields.
// [R10] Bypass gives a one-bit serial path.
// [R11] Sample captures chip inputs while the chip runs normally.
// [R12] Sample also preloads the boundary output latches.
// [R13] Clamp selects bypass while the boundary cells drive the pins.
// [R14] Extest drives and observes the pins from the boundary register.
// [R15] Intest drives and observes the core logic from the boundary register.
// [R16] One private vendor test instruction is decoded.
// [R17] Standard sixteen states; mode sampled rising, data out on falling.
// [R18] All-ones opcode and undefined opcodes act as bypass.
`timescale 1ns/1ps
`include "tap_regs.svh"
module boundary_scan_tap
#(
  parameter int BSR_IN = 8,
  parameter int BSR_OUT = 8,
  parameter logic [3:0] ID_VERSION = 4'h1, // Arbitrary value.
  parameter logic [15:0] ID_PART = 16'h1234, // Arbitrary value.
  parameter logic [10:0] ID_MFR = 11'h055 // Arbitrary value.
)
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic tck,
  input wire logic trst_n,
  input wire tap_pkg::scan_in_t scan_in,
  output tap_pkg::scan_out_t scan_out,
  input wire logic [BSR_IN-1:0] pin_in,
  input wire logic [BSR_OUT-1:0] core_out,
  output logic [BSR_OUT-1:0] pin_out,
  output logic [BSR_IN-1:0] core_in,
  output tap_pkg::test_ctrl_t test_ctrl
);
  localparam int BSR_LEN = BSR_IN + BSR_OUT;

  if (BSR_IN < 1 || BSR_OUT < 1)
  begin : g_bad_chain
    $error("boundary chain needs at least one cell per side");
  end

  // ----------------------------------------------------------------------
  // Controller state, clocked by the test clock
  // ----------------------------------------------------------------------
  tap_pkg::tap_state_t state_r;
  tap_pkg::tap_state_t state_nxt;
  logic tms;
  logic tdi;

  assign tms = scan_in.tms; // see [R1]
  assign tdi = scan_in.tdi;

  always_comb
  begin
    state_nxt = tap_pkg::TLR;
    case (state_r) // see [R17]
      tap_pkg::TLR: state_nxt = tms ? tap_pkg::TLR : tap_pkg::RTI;
      tap_pkg::RTI: state_nxt = tms ? tap_pkg::SDS : tap_pkg::RTI;
      tap_pkg::SDS: state_nxt = tms ? tap_pkg::SIS : tap_pkg::CDR;
      tap_pkg::CDR: state_nxt = tms ? tap_pkg::E1D : tap_pkg::SDR;
      tap_pkg::SDR: state_nxt = tms ? tap_pkg::E1D : tap_pkg::SDR;
      tap_pkg::E1D: state_nxt = tms ? tap_pkg::UDR : tap_pkg::PDR;
      tap_pkg::PDR: state_nxt = tms ? tap_pkg::E2D : tap_pkg::PDR;
      tap_pkg::E2D: state_nxt = tms ? tap_pkg::UDR : tap_pkg::SDR;
      tap_pkg::UDR: state_nxt = tms ? tap_pkg::SDS : tap_pkg::RTI;
      tap_pkg::SIS: state_nxt = tms ? tap_pkg::TLR : tap_pkg::CIR;
      tap_pkg::CIR: state_nxt = tms ? tap_pkg::E1I : tap_pkg::SIR;
      tap_pkg::SIR: state_nxt = tms ? tap_pkg::E1I : tap_pkg::SIR;
      tap_pkg::E1I: state_nxt = tms ? tap_pkg::UIR : tap_pkg::PIR;
      tap_pkg::PIR: state_nxt = tms ? tap_pkg::E2I : tap_pkg::PIR;
      tap_pkg::E2I: state_nxt = tms ? tap_pkg::UIR : tap_pkg::SIR;
      tap_pkg::UIR: state_nxt = tms ? tap_pkg::SDS : tap_pkg::RTI;
      default: state_nxt = tap_pkg::TLR;
    endcase
  end

  // Test reset acts without the test clock and wins over everything.
  always_ff @(posedge tck or negedge trst_n)
  begin
    if (!trst_n)
      state_r <= tap_pkg::TLR; // see [R5] see [R3]
    else
      state_r <= state_nxt;
  end

  // ----------------------------------------------------------------------
  // Instruction register
  // ----------------------------------------------------------------------
  logic [`IR_WIDTH-1:0] ir_shift_r;
  logic [`IR_WIDTH-1:0] ir_r;

  always_ff @(posedge tck or negedge trst_n)
  begin
    if (!trst_n)
      ir_shift_r <= `IR_CAPTURE;
    else if (state_r == tap_pkg::CIR)
      ir_shift_r <= `IR_CAPTURE;
    else if (state_r == tap_pkg::SIR)
      ir_shift_r <= {tdi, ir_shift_r[`IR_WIDTH-1:1]};
  end

  // The active instruction changes on the falling edge, as the standard does.
  always_ff @(negedge tck or negedge trst_n)
  begin
    if (!trst_n)
      ir_r <= `IR_IDCODE; // see [R4]
    else if (state_r == tap_pkg::TLR)
      ir_r <= `IR_IDCODE; // see [R4]
    else if (state_r == tap_pkg::UIR)
      ir_r <= ir_shift_r;
  end

  // ----------------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------------
  logic sel_id;
  logic sel_bsr;
  logic drive_pins;
  logic drive_core;
  logic is_clamp;
  logic is_private;

  always_comb
  begin
    sel_id = 1'b0;
    sel_bsr = 1'b0;
    drive_pins = 1'b0;
    drive_core = 1'b0;
    is_clamp = 1'b0;
    is_private = 1'b0;
    case (ir_r) // see [R2]
      `IR_EXTEST:
      begin
        sel_bsr = 1'b1;
        drive_pins = 1'b1; // see [R14]
      end
      `IR_SAMPLE: sel_bsr = 1'b1; // see [R11] see [R12]
      `IR_IDCODE: sel_id = 1'b1; // see [R6]
      `IR_INTEST:
      begin
        sel_bsr = 1'b1;
        drive_core = 1'b1; // see [R15]
      end
      `IR_CLAMP:
      begin
        drive_pins = 1'b1; // see [R13]
        is_clamp = 1'b1;
      end
      `IR_PRIVATE: is_private = 1'b1; // see [R16]
      default: ; // see [R18]
    endcase
  end

  // ----------------------------------------------------------------------
  // Data registers
  // ----------------------------------------------------------------------
  logic bypass_r;
  logic [`ID_WIDTH-1:0] id_r;
  logic [`ID_WIDTH-1:0] id_code;
  logic [BSR_LEN-1:0] bsr_r;
  logic [BSR_OUT-1:0] bsr_upd_out_r;
  logic [BSR_IN-1:0] bsr_upd_in_r;

  assign id_code[`ID_VERSION_MSB:`ID_VERSION_LSB] = ID_VERSION; // see [R9]
  assign id_code[`ID_PART_MSB:`ID_PART_LSB] = ID_PART;
  assign id_code[`ID_MFR_MSB:`ID_MFR_LSB] = ID_MFR;
  assign id_code[`ID_MARKER_BIT] = 1'b1;

  always_ff @(posedge tck or negedge trst_n)
  begin
    if (!trst_n)
      bypass_r <= 1'b0;
    else if (state_r == tap_pkg::CDR)
      bypass_r <= 1'b0;
    else if (state_r == tap_pkg::SDR)
      bypass_r <= tdi; // see [R10]
  end

  always_ff @(posedge tck or negedge trst_n)
  begin
    if (!trst_n)
      id_r <= '0;
    else if (state_r == tap_pkg::CDR && sel_id)
      id_r <= id_code; // see [R7]
    else if (state_r == tap_pkg::SDR && sel_id)
      id_r <= {tdi, id_r[`ID_WIDTH-1:1]}; // see [R8]
  end

  // Chain order from data in: output cells, then input cells.
  always_ff @(posedge tck or negedge trst_n)
  begin
    if (!trst_n)
      bsr_r <= '0;
    else if (state_r == tap_pkg::CDR && sel_bsr)
      bsr_r <= drive_core ? {core_out, bsr_upd_in_r} : {core_out, pin_in};
    else if (state_r == tap_pkg::SDR && sel_bsr)
      bsr_r <= {tdi, bsr_r[BSR_LEN-1:1]};
  end

  always_ff @(negedge tck or negedge trst_n)
  begin
    if (!trst_n)
    begin
      bsr_upd_out_r <= '0;
      bsr_upd_in_r <= '0;
    end
    else if (state_r == tap_pkg::UDR && sel_bsr)
    begin
      bsr_upd_out_r <= bsr_r[BSR_LEN-1:BSR_IN]; // see [R12]
      bsr_upd_in_r <= bsr_r[BSR_IN-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Serial output on the falling edge
  // ----------------------------------------------------------------------
  logic tdo_r;
  logic tdo_oe_r;
  logic dr_bit;

  always_comb
  begin
    if (sel_id)
      dr_bit = id_r[0];
    else if (sel_bsr)
      dr_bit = bsr_r[0];
    else
      dr_bit = bypass_r;
  end

  always_ff @(negedge tck or negedge trst_n)
  begin
    if (!trst_n)
    begin
      tdo_r <= 1'b0;
      tdo_oe_r <= 1'b0;
    end
    else
    begin
      tdo_r <= (state_r == tap_pkg::SIR) ? ir_shift_r[0] : dr_bit; // see [R17]
      tdo_oe_r <= (state_r == tap_pkg::SIR) || (state_r == tap_pkg::SDR);
    end
  end

  assign scan_out.tdo = tdo_r;
  assign scan_out.tdo_oe = tdo_oe_r;

  // ----------------------------------------------------------------------
  // Pin and core muxing; test mode crosses into the system clock
  // ----------------------------------------------------------------------
  logic pins_tck;
  logic core_tck;
  logic [$bits(tap_pkg::test_ctrl_t)-1:0] mode_tck;
  logic [$bits(tap_pkg::test_ctrl_t)-1:0] mode_tck_r;
  logic [$bits(tap_pkg::test_ctrl_t)-1:0] mode_sync;
  logic [$bits(tap_pkg::test_ctrl_t)-1:0] mode_prev_r;

  assign pins_tck = drive_pins;
  assign core_tck = drive_core;
  assign mode_tck = {pins_tck | core_tck, is_clamp, core_tck, is_private};

  // The decoded mode is registered so that no decode glitch can reach
  // the synchroniser.
  always_ff @(posedge tck or negedge trst_n)
  begin
    if (!trst_n)
      mode_tck_r <= '0;
    else
      mode_tck_r <= mode_tck;
  end

  tap_sync #(.WIDTH($bits(tap_pkg::test_ctrl_t))) u_mode_sync
  (
    .clk(mclk),
    .rst_n(rstn),
    .ce(ce),
    .d(mode_tck_r),
    .q(mode_sync)
  );

  // The mode bits may settle in different cycles, so a new word is only
  // taken once two samples in a row agree.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      mode_prev_r <= '0;
    else if (ce)
      mode_prev_r <= mode_sync;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      test_ctrl <= '0;
    else if (ce && mode_sync == mode_prev_r)
      test_ctrl <= mode_sync;
  end

  assign pin_out = pins_tck ? bsr_upd_out_r : core_out; // see [R13] see [R14]
  assign core_in = core_tck ? bsr_upd_in_r : pin_in; // see [R11] see [R15]
endmodule // boundary_scan_tap

// *** test/tap_checker_asserts.sv ***
// Concurrent checks on the ports of the boundary-scan test access port.
`timescale 1ns/1ps
module tap_checker
#(
  parameter int BSR_IN = 8,
  parameter int BSR_OUT = 8
)
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic tck,
  input wire logic trst_n,
  input wire tap_pkg::scan_in_t scan_in,
  input wire tap_pkg::scan_out_t scan_out,
  input wire logic [BSR_IN-1:0] pin_in,
  input wire logic [BSR_OUT-1:0] core_out,
  input wire logic [BSR_OUT-1:0] pin_out,
  input wire logic [BSR_IN-1:0] core_in,
  input wire tap_pkg::test_ctrl_t test_ctrl
);
  AST_OE_HOLD: assert property (@(posedge tck)
    disable iff (!trst_n)
    scan_out.tdo_oe && !scan_in.tms |=> scan_out.tdo_oe)
    else $error("output enable lost in shift");
  AST_OE_EXIT: assert property (@(posedge tck)
    disable iff (!trst_n)
    scan_out.tdo_oe && scan_in.tms |=> !scan_out.tdo_oe)
    else $error("output enable kept after shift");
  AST_OE_ENTRY: assert property (@(posedge tck)
    disable iff (!trst_n)
    !scan_out.tdo_oe && scan_in.tms |=> !scan_out.tdo_oe)
    else $error("shift entered with mode high");
  AST_TLR_FUNC: assert property (@(posedge tck)
    disable iff (!trst_n)
    scan_in.tms [*5] |=> !scan_out.tdo_oe && pin_out == core_out
    && core_in == pin_in)
    else $error("pins not functional after five mode ones");
  AST_TRST_TDO: assert property (@(posedge mclk)
    disable iff (!rstn)
    !trst_n |-> !scan_out.tdo_oe && !scan_out.tdo)
    else $error("data out active in test reset");
  AST_TRST_FUNC: assert property (@(posedge mclk)
    disable iff (!rstn)
    !trst_n |-> pin_out == core_out && core_in == pin_in)
    else $error("pins not functional in test reset");
  AST_CTRL_IDLE: assert property (@(posedge mclk)
    disable iff (!rstn)
    (!trst_n && ce) [*5] |-> test_ctrl == '0)
    else $error("test controls active in test reset");
  AST_TDO_FALL: assert property (@(posedge mclk)
    disable iff (!rstn || !trst_n)
    tck && $past(tck) |-> $stable(scan_out.tdo))
    else $error("data out changed while test clock high");
endmodule // tap_checker

bind boundary_scan_tap tap_checker #(.BSR_IN(BSR_IN), .BSR_OUT(BSR_OUT))
  tap_checker_inst (.mclk(mclk), .rstn(rstn), .ce(ce), .tck(tck),
  .trst_n(trst_n), .scan_in(scan_in), .scan_out(scan_out),
  .pin_in(pin_in), .core_out(core_out), .pin_out(pin_out),
  .core_in(core_in), .test_ctrl(test_ctrl));

// *** test/jtag_tester.sv ***
// Board-level tester model that drives the five-pin test port.
`timescale 1ns/1ps
module jtag_tester
(
  output logic tck,
  output logic trst_n,
  output tap_pkg::scan_in_t scan_in,
  input wire tap_pkg::scan_out_t scan_out
);
  initial
  begin
    tck = 1'h0;
    // Test reset starts high so that the bench can give it a real falling
    // edge.
    trst_n = 1'h1;
    scan_in = '0;
  end

  // One clock period; mode and data move only while the clock is low.
  task automatic tick(input logic m, input logic d, output logic o);
    scan_in.tms = m;
    scan_in.tdi = d;
    #14;
    o = scan_out.tdo;
    tck = 1'h1;
    #16;
    tck = 1'h0;
    #2;
  endtask

  task automatic set_trst(input logic v);
    trst_n = v;
  endtask

  // From idle: capture, shift n bits low bit first, update, back to idle.
  task automatic scan(input logic ir, input logic [31:0] d, input int n,
                      output logic [31:0] q);
    logic o;
    q = '0;
    tick(1'h1, 1'h0, o);
    if (ir)
    begin
      tick(1'h1, 1'h0, o);
    end
    tick(1'h0, 1'h0, o);
    tick(1'h0, 1'h0, o);
    for (int i = 0; i < n; i++)
    begin
      tick(i == n - 1, d[i], o);
      q[i] = o;
    end
    tick(1'h1, 1'h0, o);
    tick(1'h0, 1'h0, o);
  endtask
endmodule // jtag_tester

// *** test/test_boundary_scan_tap.sv ***
// Self-checking bench for the boundary-scan test access port.
`timescale 1ns/1ps
`include "tap_regs.svh"
module test_boundary_scan_tap;
  typedef struct packed {
    logic [3:0] op;
    logic [1:0] kind;
    logic pin_latch;
    logic core_latch;
    logic priv;
  } row_t;
  // Identification fields are arbitrary values.
  localparam logic [31:0] ID_EXP = {4'h6, 16'hA5C3, 11'h2B1, 1'h1};
  logic mclk = 1'h0;
  logic rstn = 1'h1;
  logic ce = 1'h1;
  logic tck;
  logic trst_n;
  logic b;
  tap_pkg::scan_in_t scan_in;
  tap_pkg::scan_out_t scan_out;
  tap_pkg::test_ctrl_t test_ctrl;
  logic [7:0] pin_in = 8'h3C;
  logic [7:0] core_out = 8'h96;
  logic [7:0] pin_out;
  logic [7:0] core_in;
  logic [31:0] q;
  logic [3:0] exp_ctrl;
  int miscompares = 0;
  int comparisons = 0;
  // Kind: 0 boundary chain, 1 one-bit path, 2 identification, 3 private.
  row_t rows [9] = '{
    '{`IR_EXTEST, 2'h0, 1'h1, 1'h0, 1'h0}, '{`IR_SAMPLE, 2'h0, 1'h0, 1'h0, 1'h0},
    '{`IR_IDCODE, 2'h2, 1'h0, 1'h0, 1'h0}, '{`IR_INTEST, 2'h0, 1'h0, 1'h1, 1'h0},
    '{`IR_CLAMP, 2'h1, 1'h1, 1'h0, 1'h0}, '{`IR_PRIVATE, 2'h3, 1'h0, 1'h0, 1'h1},
    '{`IR_BYPASS, 2'h1, 1'h0, 1'h0, 1'h0}, '{4'h5, 2'h1, 1'h0, 1'h0, 1'h0},
    '{4'hE, 2'h1, 1'h0, 1'h0, 1'h0}};

  always #2 mclk = ~mclk;

  boundary_scan_tap #(.ID_VERSION(4'h6), .ID_PART(16'hA5C3),
    .ID_MFR(11'h2B1)) boundary_scan_tap_inst (.mclk(mclk), .rstn(rstn),
    .ce(ce), .tck(tck), .trst_n(trst_n), .scan_in(scan_in),
    .scan_out(scan_out), .pin_in(pin_in), .core_out(core_out),
    .pin_out(pin_out), .core_in(core_in), .test_ctrl(test_ctrl));

  jtag_tester jtag_tester_inst (.tck(tck), .trst_n(trst_n),
    .scan_in(scan_in), .scan_out(scan_out));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic load_ir(input logic [3:0] op);
    jtag_tester_inst.scan(1'h1, {28'h0, op}, 4, q);
    chk(q, 32'h1);
  endtask

  task automatic read_id();
    jtag_tester_inst.scan(1'h0, 32'h0, 32, q);
    chk(q, ID_EXP);
  endtask

  task automatic final_report();
    $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
    begin
      $display("Simulation passed");
    end
    else
    begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial
  begin
    #200000;
    miscompares++;
    final_report();
  end

  initial
  begin
    #1;
    rstn = 1'h0;
    jtag_tester_inst.set_trst(1'h0);
    repeat (6) @(posedge mclk);
    #1;
    rstn = 1'h1;
    jtag_tester_inst.set_trst(1'h1);
    jtag_tester_inst.tick(1'h0, 1'h0, b);
    chk({28'h0, test_ctrl}, 32'h0);
    read_id();
    $display("reset test done");
    load_ir(`IR_SAMPLE);
    jtag_tester_inst.scan(1'h0, 32'hFFFF, 16, q);
    chk({24'h0, q[7:0]}, {24'h0, pin_in});
    chk({24'h0, q[15:8]}, {24'h0, core_out});
    chk({24'h0, pin_out}, {24'h0, core_out});
    $display("sample test done");
    foreach (rows[i])
    begin
      load_ir(rows[i].op);
      repeat (5) @(posedge mclk);
      #1;
      exp_ctrl = {rows[i].pin_latch | rows[i].core_latch,
        rows[i].pin_latch & (rows[i].kind == 2'h1), rows[i].core_latch,
        rows[i].priv};
      chk({28'h0, test_ctrl}, {28'h0, exp_ctrl});
      if (rows[i].kind != 2'h3)
      begin
        chk({24'h0, pin_out},
          rows[i].pin_latch ? 32'hFF : {24'h0, core_out});
        chk({24'h0, core_in},
          rows[i].core_latch ? 32'hFF : {24'h0, pin_in});
      end
      if (rows[i].kind == 2'h1)
      begin
        jtag_tester_inst.scan(1'h0, 32'hA5, 8, q);
        chk(q, 32'h4A);
      end
      if (rows[i].kind == 2'h2)
      begin
        read_id();
      end
      if (rows[i].kind == 2'h0)
      begin
        jtag_tester_inst.scan(1'h0, 32'hFFFF, 16, q);
        chk({24'h0, q[7:0]},
          rows[i].core_latch ? 32'hFF : {24'h0, pin_in});
      end
      $display("row %0d done", i);
    end
    @(posedge mclk);
    #1;
    ce = 1'h0;
    load_ir(`IR_EXTEST);
    repeat (5) @(posedge mclk);
    #1;
    chk({28'h0, test_ctrl}, 32'h0);
    ce = 1'h1;
    repeat (6) @(posedge mclk);
    #1;
    chk({28'h0, test_ctrl}, 32'h8);
    $display("clock enable test done");
    load_ir(`IR_BYPASS);
    jtag_tester_inst.tick(1'h1, 1'h0, b);
    jtag_tester_inst.tick(1'h0, 1'h0, b);
    jtag_tester_inst.tick(1'h0, 1'h1, b);
    chk({31'h0, scan_out.tdo_oe}, 32'h1);
    jtag_tester_inst.set_trst(1'h0);
    #1;
    chk({30'h0, scan_out}, 32'h0);
    repeat (10) @(posedge mclk);
    #1;
    jtag_tester_inst.set_trst(1'h1);
    jtag_tester_inst.tick(1'h0, 1'h0, b);
    read_id();
    $display("async reset test done");
    load_ir(`IR_BYPASS);
    repeat (5) jtag_tester_inst.tick(1'h1, 1'h0, b);
    jtag_tester_inst.tick(1'h0, 1'h0, b);
    read_id();
    $display("mode reset test done");
    final_report();
  end
endmodule // test_boundary_scan_tap
